/* design/pmcg_regs.vh */
// Overview of operation
// - mode 11 total power-down, brownout and comparators off
// - total power-down ignores comparator, brownout wake
// - rc oscillator stops unless system clock with rtc
// - wake on level external interrupts and keyboard
// - watchdog wakes when its clock select is 1
// - rtc and its crystal run unless rtc gated
// - mode bits 1:0, general flags bits 2,3
// - bit 4 picks brownout interrupt or reset
// - bit 5 powers down brownout detection
// - program/erase aborted while brownout power-down set
// - bit 6 steers serial bit 7 access
// - bit 7 doubles timer 1 baud rate
// - capture unit clock off by bit, mode, fuse
// - uart clock off by bit or power-down
// - spi clock off by bit or power-down
// - i2c clock off by bit or power-down
// - converter clock off by bit 4
// - comparators powered down by bit 5
// - data eeprom off by bit or power-down
// - bit 7 gates real-time clock clock
// - mode 00 normal, 01 idle, 10 power-down
// - wake waits 1024 crystal or 256 clocks
`ifndef PMCG_REGS_VH
`define PMCG_REGS_VH

// register addresses
`define PMCG_PWR_CTRL_ADDR 8'h87
`define PMCG_PERIPH_GATE_ADDR 8'hB5
`define PMCG_STATUS_ADDR 8'hB6

// reset values
`define PMCG_PWR_CTRL_RST 8'h00
`define PMCG_PERIPH_GATE_RST 8'h00

// power_control fields
`define PMCG_MODE_LO 0
`define PMCG_MODE_HI 1
`define PMCG_GEN_FLAG_ZERO 2
`define PMCG_GEN_FLAG_ONE 3
`define PMCG_BROWNOUT_IRQ_SEL 4
`define PMCG_BROWNOUT_PD 5
`define PMCG_FRAMING_ERR_SEL 6
`define PMCG_BAUD_DOUBLER 7

// peripheral_power_gating fields
`define PMCG_CAPTURE_GATE 0
`define PMCG_UART_GATE 1
`define PMCG_SPI_GATE 2
`define PMCG_I2C_GATE 3
`define PMCG_CONVERTER_GATE 4
`define PMCG_COMPARATOR_PD 5
`define PMCG_EEPROM_PD 6
`define PMCG_RTC_GATE 7

// power mode encodings
`define PMCG_MODE_NORMAL 2'b00
`define PMCG_MODE_IDLE 2'b01
`define PMCG_MODE_PD 2'b10
`define PMCG_MODE_TOTAL_PD 2'b11

// oscillator stability counts in clocks
`define PMCG_XTAL_STABLE_CLKS 11'd1024
`define PMCG_RC_STABLE_CLKS 11'd256

`endif

/* design/pmcg_top.v */
`timescale 1ns/1ps
`include "pmcg_regs.vh"

module pmcg_top (
  // clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata_ff,
  // asynchronous wake and event sources
  input wire [1:0] i_ext_irq,
  input wire i_keyboard_irq,
  input wire i_rtc_event,
  input wire i_wdt_irq,
  input wire i_wdt_reset,
  input wire i_comparator_trip,
  input wire i_brownout_detect,
  // same-clock configuration and events
  input wire [1:0] i_ext_level_mode,
  input wire i_global_irq_enable,
  input wire i_any_irq,
  input wire i_watchdog_clock_select,
  input wire i_crystal_cfg,
  input wire i_rc_is_sysclk,
  input wire i_rtc_enable,
  input wire i_rtc_uses_xtal,
  input wire i_capture_unit_fuse_disable,
  input wire i_prog_cmd,
  input wire i_t1_overflow,
  // serial control bit 7 access
  input wire i_scon7_wr,
  input wire i_scon7_wdata,
  input wire i_serial_mode_bit,
  input wire i_framing_error_status,
  output reg o_serial_mode_wr_ff,
  output reg o_framing_error_wr_ff,
  output reg o_scon7_wdata_ff,
  output reg o_scon7_rdata_ff,
  // oscillators and cpu
  output reg o_cpu_clk_en_ff,
  output reg o_sys_osc_run_ff,
  output reg o_rc_osc_run_ff,
  output reg o_xtal_run_ff,
  // brownout
  output reg o_bod_enable_ff,
  output reg o_bod_reset_ff,
  output reg o_bod_irq_ff,
  // flash commands
  output reg o_prog_go_ff,
  output reg o_prog_abort_ff,
  // uart baud
  output reg o_uart_baud_tick_ff,
  // peripheral clock enables and power
  output reg o_capture_clk_en_ff,
  output reg o_uart_clk_en_ff,
  output reg o_spi_clk_en_ff,
  output reg o_i2c_clk_en_ff,
  output reg o_converter_clk_en_ff,
  output reg o_comparator_power_ff,
  output reg o_eeprom_power_ff,
  output reg o_rtc_clk_en_ff
);

  // one-hot power states
  localparam [4:0] ST_NORMAL = 5'b00001;
  localparam [4:0] ST_IDLE = 5'b00010;
  localparam [4:0] ST_PD = 5'b00100;
  localparam [4:0] ST_TPD = 5'b01000;
  localparam [4:0] ST_WAKE = 5'b10000;

  reg [7:0] power_control_ff;
  reg [7:0] periph_gate_ff;
  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [10:0] stable_cnt_ff;
  reg [10:0] nxt_stable_cnt;
  reg clear_mode;
  reg baud_half_ff;
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;

  wire [7:0] async_in;
  wire [1:0] s_ext;
  wire s_kbd;
  wire s_rtc;
  wire s_wdt_irq;
  wire s_wdt_rst;
  wire s_cmp;
  wire s_bod;
  wire [1:0] mode;
  wire pd_any;
  wire tpd;
  wire ext_wake;
  wire wdt_wake;
  wire common_wake;
  wire pd_wake;
  wire tpd_wake;
  wire bod_en;
  wire [10:0] stable_len;

  // gather asynchronous sources
  assign async_in = {i_brownout_detect, i_comparator_trip, i_wdt_reset,
                     i_wdt_irq, i_rtc_event, i_keyboard_irq, i_ext_irq};

  // two-flop synchroniser per source
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_sync
      always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
        end else begin
          sync1_ff[g] <= async_in[g];
          sync2_ff[g] <= sync1_ff[g];
        end
      end
    end
  endgenerate

  // synchronised source names
  assign s_ext = sync2_ff[1:0];
  assign s_kbd = sync2_ff[2];
  assign s_rtc = sync2_ff[3];
  assign s_wdt_irq = sync2_ff[4];
  assign s_wdt_rst = sync2_ff[5];
  assign s_cmp = sync2_ff[6];
  assign s_bod = sync2_ff[7];

  // decoded mode and power states
  assign mode = power_control_ff[`PMCG_MODE_HI:`PMCG_MODE_LO];
  assign pd_any = (state_ff == ST_PD) | (state_ff == ST_TPD);
  assign tpd = (state_ff == ST_TPD);

  // brownout detection enable
  assign bod_en = ~power_control_ff[`PMCG_BROWNOUT_PD] & ~tpd;

  // wake qualification
  assign ext_wake = |(s_ext & i_ext_level_mode);
  assign wdt_wake = i_watchdog_clock_select & (s_wdt_irq | s_wdt_rst);
  assign common_wake = (i_global_irq_enable & (ext_wake | s_kbd | s_rtc)) |
                       wdt_wake;
  assign pd_wake = common_wake |
                   (i_global_irq_enable & s_cmp) |
                   (i_global_irq_enable & bod_en & s_bod &
                    power_control_ff[`PMCG_BROWNOUT_IRQ_SEL]);
  assign tpd_wake = common_wake;

  // stability length by oscillator kind
  assign stable_len = i_crystal_cfg ? `PMCG_XTAL_STABLE_CLKS
                                    : `PMCG_RC_STABLE_CLKS;

  // power state machine
  always @* begin
    nxt_state = state_ff;
    nxt_stable_cnt = stable_cnt_ff;
    clear_mode = 1'b0;
    case (state_ff)
      ST_NORMAL: begin
        case (mode)
          `PMCG_MODE_IDLE: nxt_state = ST_IDLE;
          `PMCG_MODE_PD: nxt_state = ST_PD;
          `PMCG_MODE_TOTAL_PD: nxt_state = ST_TPD;
          default: nxt_state = ST_NORMAL;
        endcase
      end
      ST_IDLE: begin
        if (i_any_irq) begin
          nxt_state = ST_NORMAL;
          clear_mode = 1'b1;
        end
      end
      ST_PD: begin
        if (pd_wake) begin
          nxt_state = ST_WAKE;
          nxt_stable_cnt = stable_len - 11'd1;
          clear_mode = 1'b1;
        end
      end
      ST_TPD: begin
        if (tpd_wake) begin
          nxt_state = ST_WAKE;
          nxt_stable_cnt = stable_len - 11'd1;
          clear_mode = 1'b1;
        end
      end
      ST_WAKE: begin
        if (stable_cnt_ff == 11'd0) begin
          nxt_state = ST_NORMAL;
        end else begin
          nxt_stable_cnt = stable_cnt_ff - 11'd1;
        end
      end
      default: begin
        nxt_state = ST_NORMAL;
        nxt_stable_cnt = 11'd0;
      end
    endcase
  end

  // state and counter registers
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_NORMAL;
      stable_cnt_ff <= 11'd0;
    end else begin
      state_ff <= nxt_state;
      stable_cnt_ff <= nxt_stable_cnt;
    end
  end

  // software registers; a write beats the wake clear of the mode
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      power_control_ff <= `PMCG_PWR_CTRL_RST;
      periph_gate_ff <= `PMCG_PERIPH_GATE_RST;
    end else begin
      if (i_wr && i_addr == `PMCG_PWR_CTRL_ADDR) begin
        power_control_ff <= i_wdata;
      end else if (clear_mode) begin
        power_control_ff[`PMCG_MODE_HI:`PMCG_MODE_LO] <= `PMCG_MODE_NORMAL;
      end
      if (i_wr && i_addr == `PMCG_PERIPH_GATE_ADDR) begin
        periph_gate_ff <= i_wdata;
      end
    end
  end

  // read data, valid the cycle after the strobe
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata_ff <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `PMCG_PWR_CTRL_ADDR: o_rdata_ff <= power_control_ff;
        `PMCG_PERIPH_GATE_ADDR: o_rdata_ff <= periph_gate_ff;
        `PMCG_STATUS_ADDR: o_rdata_ff <= {3'b000, state_ff};
        default: o_rdata_ff <= 8'h00;
      endcase
    end else begin
      o_rdata_ff <= 8'h00;
    end
  end

  // serial control bit 7 steering
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_serial_mode_wr_ff <= 1'b0;
      o_framing_error_wr_ff <= 1'b0;
      o_scon7_wdata_ff <= 1'b0;
      o_scon7_rdata_ff <= 1'b0;
    end else begin
      o_serial_mode_wr_ff <= i_scon7_wr &
        ~power_control_ff[`PMCG_FRAMING_ERR_SEL];
      o_framing_error_wr_ff <= i_scon7_wr &
        power_control_ff[`PMCG_FRAMING_ERR_SEL];
      o_scon7_wdata_ff <= i_scon7_wdata;
      o_scon7_rdata_ff <= power_control_ff[`PMCG_FRAMING_ERR_SEL] ?
        i_framing_error_status : i_serial_mode_bit;
    end
  end

  // timer 1 baud halving
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      baud_half_ff <= 1'b0;
      o_uart_baud_tick_ff <= 1'b0;
    end else begin
      if (i_t1_overflow) begin
        baud_half_ff <= ~baud_half_ff;
      end
      o_uart_baud_tick_ff <= i_t1_overflow &
        (power_control_ff[`PMCG_BAUD_DOUBLER] | baud_half_ff);
    end
  end

  // brownout action and flash command gating
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bod_enable_ff <= 1'b0;
      o_bod_reset_ff <= 1'b0;
      o_bod_irq_ff <= 1'b0;
      o_prog_go_ff <= 1'b0;
      o_prog_abort_ff <= 1'b0;
    end else begin
      o_bod_enable_ff <= bod_en;
      o_bod_reset_ff <= bod_en & s_bod &
        ~power_control_ff[`PMCG_BROWNOUT_IRQ_SEL];
      o_bod_irq_ff <= bod_en & s_bod &
        power_control_ff[`PMCG_BROWNOUT_IRQ_SEL];
      o_prog_go_ff <= i_prog_cmd &
        ~power_control_ff[`PMCG_BROWNOUT_PD];
      o_prog_abort_ff <= i_prog_cmd &
        power_control_ff[`PMCG_BROWNOUT_PD];
    end
  end

  // oscillator and cpu run controls
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cpu_clk_en_ff <= 1'b0;
      o_sys_osc_run_ff <= 1'b0;
      o_rc_osc_run_ff <= 1'b0;
      o_xtal_run_ff <= 1'b0;
    end else begin
      o_cpu_clk_en_ff <= (nxt_state == ST_NORMAL);
      o_sys_osc_run_ff <= ~pd_any;
      o_rc_osc_run_ff <= ~pd_any |
        (i_rc_is_sysclk & i_rtc_enable);
      o_xtal_run_ff <= ~pd_any |
        (i_rtc_enable & i_rtc_uses_xtal &
         ~periph_gate_ff[`PMCG_RTC_GATE]);
    end
  end

  // peripheral clock and power enables
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_capture_clk_en_ff <= 1'b0;
      o_uart_clk_en_ff <= 1'b0;
      o_spi_clk_en_ff <= 1'b0;
      o_i2c_clk_en_ff <= 1'b0;
      o_converter_clk_en_ff <= 1'b0;
      o_comparator_power_ff <= 1'b0;
      o_eeprom_power_ff <= 1'b0;
      o_rtc_clk_en_ff <= 1'b0;
    end else begin
      o_capture_clk_en_ff <= ~periph_gate_ff[`PMCG_CAPTURE_GATE] &
        ~pd_any & ~i_capture_unit_fuse_disable;
      o_uart_clk_en_ff <= ~periph_gate_ff[`PMCG_UART_GATE] &
        ~pd_any;
      o_spi_clk_en_ff <= ~periph_gate_ff[`PMCG_SPI_GATE] &
        ~pd_any;
      o_i2c_clk_en_ff <= ~periph_gate_ff[`PMCG_I2C_GATE] &
        ~pd_any;
      o_converter_clk_en_ff <=
        ~periph_gate_ff[`PMCG_CONVERTER_GATE];
      o_comparator_power_ff <= ~periph_gate_ff[`PMCG_COMPARATOR_PD] &
        ~tpd;
      o_eeprom_power_ff <= ~periph_gate_ff[`PMCG_EEPROM_PD] &
        ~pd_any;
      o_rtc_clk_en_ff <= ~periph_gate_ff[`PMCG_RTC_GATE];
    end
  end

endmodule

/* verif/pmcg_checker.sv */
`timescale 1ns/1ps
module pmcg_checker (
  // clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // watched inputs
  input wire i_rd,
  input wire i_prog_cmd,
  input wire i_t1_overflow,
  input wire i_scon7_wr,
  input wire i_scon7_wdata,
  input wire i_capture_unit_fuse_disable,
  // watched outputs
  input wire [7:0] o_rdata_ff,
  input wire o_prog_go_ff,
  input wire o_prog_abort_ff,
  input wire o_bod_enable_ff,
  input wire o_bod_reset_ff,
  input wire o_bod_irq_ff,
  input wire o_sys_osc_run_ff,
  input wire o_uart_clk_en_ff,
  input wire o_spi_clk_en_ff,
  input wire o_i2c_clk_en_ff,
  input wire o_eeprom_power_ff,
  input wire o_capture_clk_en_ff,
  input wire o_serial_mode_wr_ff,
  input wire o_framing_error_wr_ff,
  input wire o_scon7_wdata_ff,
  input wire o_uart_baud_tick_ff
);
  // one clock domain, reset aborts every attempt
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // bus, flash, brownout, gating and serial relations
  a_rdata_quiet: assert property (
    !$past(i_rd) |-> o_rdata_ff == 8'h00) else $error("rdata not idle");
  a_prog_answer: assert property (
    i_prog_cmd |=> o_prog_go_ff ^ o_prog_abort_ff) else $error("prog answer");
  a_prog_cause: assert property (
    (o_prog_go_ff || o_prog_abort_ff) |-> $past(i_prog_cmd))
    else $error("prog without cmd");
  a_bod_quiet: assert property (
    !o_bod_enable_ff [*2] |-> !o_bod_reset_ff && !o_bod_irq_ff)
    else $error("brownout action while off");
  a_pd_gates: assert property (
    !o_sys_osc_run_ff |-> !(o_uart_clk_en_ff | o_spi_clk_en_ff |
    o_i2c_clk_en_ff | o_eeprom_power_ff | o_capture_clk_en_ff))
    else $error("clock on in power-down");
  a_serial_route: assert property (
    i_scon7_wr |=> (o_serial_mode_wr_ff ^ o_framing_error_wr_ff) &&
    o_scon7_wdata_ff == $past(i_scon7_wdata)) else $error("bit7 route");
  a_baud_cause: assert property (
    o_uart_baud_tick_ff |-> $past(i_t1_overflow)) else $error("stray tick");
  a_fuse_capture: assert property (
    i_capture_unit_fuse_disable [*2] |-> !o_capture_clk_en_ff)
    else $error("capture clock with fuse");

  // main scenarios reached
  c_abort: cover property (o_prog_abort_ff);
  c_pd: cover property (!o_sys_osc_run_ff);
  c_bod_irq: cover property (o_bod_irq_ff);
endmodule

/* verif/tb_power_mode_clock_gating.sv */
`timescale 1ns/1ps
module tb_power_mode_clock_gating;
  logic i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0;
  logic [7:0] i_addr = 0, i_wdata = 0;
  logic [1:0] i_ext_irq = 0, i_ext_level_mode = 0;
  logic i_keyboard_irq = 0, i_rtc_event = 0, i_wdt_irq = 0;
  logic i_wdt_reset = 0, i_comparator_trip = 0, i_brownout_detect = 0;
  logic i_global_irq_enable = 1, i_any_irq = 0;
  logic i_watchdog_clock_select = 0, i_crystal_cfg = 0;
  logic i_rc_is_sysclk = 0, i_rtc_enable = 0, i_rtc_uses_xtal = 0;
  logic i_capture_unit_fuse_disable = 0, i_prog_cmd = 0;
  logic i_t1_overflow = 0, i_scon7_wr = 0, i_scon7_wdata = 0;
  logic i_serial_mode_bit = 0, i_framing_error_status = 0;
  wire [7:0] o_rdata_ff;
  wire o_serial_mode_wr_ff, o_framing_error_wr_ff, o_scon7_wdata_ff;
  wire o_scon7_rdata_ff, o_cpu_clk_en_ff, o_sys_osc_run_ff;
  wire o_rc_osc_run_ff, o_xtal_run_ff, o_bod_enable_ff, o_bod_reset_ff;
  wire o_bod_irq_ff, o_prog_go_ff, o_prog_abort_ff, o_uart_baud_tick_ff;
  wire o_capture_clk_en_ff, o_uart_clk_en_ff, o_spi_clk_en_ff;
  wire o_i2c_clk_en_ff, o_converter_clk_en_ff, o_comparator_power_ff;
  wire o_eeprom_power_ff, o_rtc_clk_en_ff;
  // peripheral enables in power_gating bit order
  wire [7:0] en = {o_rtc_clk_en_ff, o_eeprom_power_ff,
    o_comparator_power_ff, o_converter_clk_en_ff, o_i2c_clk_en_ff,
    o_spi_clk_en_ff, o_uart_clk_en_ff, o_capture_clk_en_ff};
  int n_mismatch = 0;
  int compares = 0;

  pmcg_top u_dut (.*);

  // shared compare, bus and wait helpers
  task automatic ck(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    #1 ck(o_rdata_ff === e, "read data");
  endtask
  task automatic wake(input int lo);
    int n;
    n = 0;
    while (o_cpu_clk_en_ff !== 1'b1 && n < 1100) begin
      cyc(1);
      n++;
    end
    ck(n >= lo && n < lo + 8, "wake time");
  endtask

  // scenarios
  task automatic t_regs;
    rd(8'h87, 8'h00);
    rd(8'hB5, 8'h00);
    rd(8'hB6, 8'h01);
    wr(8'h87, 8'h0C);
    rd(8'h87, 8'h0C);
    cyc(2);
    ck(o_cpu_clk_en_ff === 1'b1, "flags");
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(8'h87, 8'h00);
  endtask
  task automatic t_gates;
    for (int i = 0; i < 8; i++) begin
      wr(8'hB5, 8'h01 << i);
      cyc(2);
      ck(en === ~(8'h01 << i), "gate bit");
    end
    wr(8'hB5, 8'h00);
    @(posedge i_clk) i_capture_unit_fuse_disable <= 1;
    cyc(3);
    ck(en === 8'hFE, "fuse");
    @(posedge i_clk) i_capture_unit_fuse_disable <= 0;
  endtask
  task automatic t_brown;
    wr(8'h87, 8'h30);
    cyc(2);
    ck(o_bod_enable_ff === 1'b0, "bod off");
    @(posedge i_clk) i_prog_cmd <= 1;
    @(posedge i_clk) i_prog_cmd <= 0;
    #1 ck({o_prog_abort_ff, o_prog_go_ff} === 2'b10, "abort");
    @(posedge i_clk) i_brownout_detect <= 1;
    wr(8'h87, 8'h10);
    cyc(4);
    ck({o_bod_irq_ff, o_bod_reset_ff} === 2'b10, "bod irq");
    wr(8'h87, 8'h00);
    cyc(4);
    ck({o_bod_irq_ff, o_bod_reset_ff} === 2'b01, "bod rst");
    @(posedge i_clk) i_brownout_detect <= 0;
    @(posedge i_clk) i_prog_cmd <= 1;
    @(posedge i_clk) i_prog_cmd <= 0;
    #1 ck({o_prog_abort_ff, o_prog_go_ff} === 2'b01, "go");
  endtask
  task automatic t_serial;
    for (int s = 0; s < 2; s++) begin
      wr(8'h87, s ? 8'h40 : 8'h00);
      i_serial_mode_bit <= !s[0];
      i_framing_error_status <= s[0];
      @(posedge i_clk) i_scon7_wr <= 1;
      i_scon7_wdata <= 1;
      @(posedge i_clk) i_scon7_wr <= 0;
      #1 ck({o_serial_mode_wr_ff, o_framing_error_wr_ff} ===
        (s ? 2'b01 : 2'b10), "bit7 wr");
      ck(o_scon7_rdata_ff === 1'b1, "bit7 rd");
    end
  endtask
  task automatic t_baud;
    int n;
    for (int b = 0; b < 2; b++) begin
      wr(8'h87, b ? 8'h80 : 8'h00);
      n = 0;
      repeat (4) begin
        @(posedge i_clk) i_t1_overflow <= 1;
        @(posedge i_clk) i_t1_overflow <= 0;
        #1 n += o_uart_baud_tick_ff;
      end
      ck(n === (b ? 4 : 2), "ticks");
    end
  endtask
  task automatic t_pd;
    @(posedge i_clk) i_crystal_cfg <= 1;
    wr(8'h87, 8'h02);
    cyc(3);
    ck({o_cpu_clk_en_ff, o_sys_osc_run_ff, en[1], o_rc_osc_run_ff,
      o_xtal_run_ff} === 5'b00000, "pd");
    rd(8'hB6, 8'h04);
    @(posedge i_clk) i_keyboard_irq <= 1;
    wake(1024);
    @(posedge i_clk) i_keyboard_irq <= 0;
    rd(8'h87, 8'h00);
  endtask
  task automatic t_tpd;
    @(posedge i_clk) i_crystal_cfg <= 0;
    i_rc_is_sysclk <= 1;
    i_rtc_enable <= 1;
    i_rtc_uses_xtal <= 1;
    wr(8'h87, 8'h03);
    cyc(3);
    ck({o_bod_enable_ff, en[5], o_rc_osc_run_ff, o_rtc_clk_en_ff,
      o_xtal_run_ff} === 5'b00111, "tpd");
    @(posedge i_clk) i_comparator_trip <= 1;
    i_brownout_detect <= 1;
    i_wdt_irq <= 1;
    i_ext_irq <= 2'b01;
    cyc(20);
    ck({o_cpu_clk_en_ff, o_bod_irq_ff, o_bod_reset_ff} === 3'b000,
      "no wake");
    @(posedge i_clk) i_ext_level_mode <= 2'b01;
    i_comparator_trip <= 0;
    i_brownout_detect <= 0;
    i_wdt_irq <= 0;
    wake(256);
    @(posedge i_clk) i_ext_irq <= 2'b00;
    i_watchdog_clock_select <= 1;
    wr(8'h87, 8'h03);
    cyc(3);
    @(posedge i_clk) i_wdt_irq <= 1;
    wake(256);
    @(posedge i_clk) i_wdt_irq <= 0;
  endtask
  task automatic t_idle;
    wr(8'h87, 8'h01);
    cyc(3);
    ck({o_cpu_clk_en_ff, en[1]} === 2'b01, "idle");
    @(posedge i_clk) i_any_irq <= 1;
    @(posedge i_clk) i_any_irq <= 0;
    cyc(3);
    ck(o_cpu_clk_en_ff === 1'b1, "idle end");
  endtask

  // verdict and end of run
  task automatic close_out;
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // 50 MHz clock
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1;
    t_regs;
    t_gates;
    t_brown;
    t_serial;
    t_baud;
    t_pd;
    t_tpd;
    t_idle;
    close_out;
  end
  // hang guard, about 10000 cycles
  initial begin
    #200000;
    n_mismatch++;
    close_out;
  end
endmodule

bind pmcg_top pmcg_checker u_chk (.*);
